// File: shared/nmd_pkg.sv
// package: constants and sine table for the nco mixer decimator block
// Contract
// R1 - 32-bit oscillator, rotation sense selectable
// R2 - frequency word is signed twos complement
// R3 - mixer multiplies real sample by oscillator
// R4 - new frequency active only after reload toggle
// R5 - software inverts mixer phase, fin minus fnco
// R6 - controller computes word as f*2^32/fs
// R7 - complex decimation by 2,4,8,16,32
// R8 - real mode gives half complex bandwidth
// R9 - alignment enable turns powerdown pin into align
// R10 - align pin captured on sampling clock edge
// R11 - alignment resets dividers, aligns I and Q
// R12 - alignment clears phase, loads pending word
// R13 - alignment from software bit or pin
// R14 - no alignment leaves dividers free running
// R15 - controller realigns only at 64-cycle multiples
// R16 - real mode bypasses mixer, low-pass only
// R17 - filter arithmetic kept at 20 bits; the code holds the sums at 25 bits and cuts the output to 20
// R18 - optional 6 dB complex, 3 dB real gain
// R19 - output word with one-cycle valid strobe
package nmd_pkg;
	localparam int NCO_W  = 32;
	localparam int SMP_W  = 16;
	localparam int ACC_W  = 20;
	localparam int SUM_W  = 25;
	localparam int CNT_W  = 5;
	localparam int PIDX_W = 6;
	localparam int AMP_W  = 17;
	localparam int ADR_W  = 8;
	localparam int DAT_W  = 32;

	// register byte addresses
	localparam logic [ADR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] ADDR_FREQ = 8'h04;
	localparam logic [ADR_W-1:0] ADDR_CMD  = 8'h08;
	localparam logic [ADR_W-1:0] ADDR_STAT = 8'h0c;
	localparam logic [ADR_W-1:0] ADDR_FACT = 8'h10;

	// control fields
	localparam int CTRL_DEC_EN   = 0;
	localparam int CTRL_REAL     = 1;
	localparam int CTRL_INVERT   = 2;
	localparam int CTRL_GAIN     = 3;
	localparam int CTRL_ALIGN_EN = 4;
	localparam int CTRL_RATIO_LO = 8;
	localparam int RATIO_W       = 3;
	localparam logic [DAT_W-1:0] CTRL_MASK = 32'h0000_071f;
	localparam logic [DAT_W-1:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [NCO_W-1:0] FREQ_RST  = 32'h0000_0000;
	localparam logic [RATIO_W-1:0] RATIO_MAX = 3'h4;

	// command and status fields
	localparam int CMD_RESTART  = 0;
	localparam int CMD_ALIGN    = 1;
	localparam int STAT_PDN     = 0;
	localparam int STAT_ALIGNED = 1;
	localparam int STAT_PEND    = 2;

	// mixer bypass scales a 16-bit sample into 20 bits
	localparam int SMP_SHIFT = 4;
	localparam int QTR_OFS   = 16;

	// quarter sine, sampled at half steps
	localparam logic [15:0] SIN_LUT [16] = '{
		16'h0648, 16'h12c8, 16'h1f1a, 16'h2b1f,
		16'h36ba, 16'h41ce, 16'h4c40, 16'h55f5,
		16'h5ed7, 16'h66cf, 16'h6dca, 16'h73b6,
		16'h7884, 16'h7c29, 16'h7e9d, 16'h7fd8
	};
endpackage

// File: shared/nmd_iq_if.sv
// interface: mixed I/Q sample stream from mixer to decimator
`timescale 1ns/100ps
`default_nettype none
interface nmd_iq_if;
	logic signed [nmd_pkg::ACC_W-1:0] i;
	logic signed [nmd_pkg::ACC_W-1:0] q;
	logic                             vld;
	modport src (output i, q, vld);
	modport snk (input i, q, vld);
endinterface
`default_nettype wire

// File: verilog/nmd_pin_sync.sv
// module: two-stage synchroniser and rise detect for the shared pin
`timescale 1ns/100ps
`default_nettype none
module nmd_pin_sync
(
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_arst_n,
	// pin and results
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} nmd_sync_st_t;

	nmd_sync_st_t r;
	nmd_sync_st_t n;

	always_comb
	begin
		n    = r;
		n.s1 = i_pin;
		n.s2 = r.s1;
		n.s3 = r.s2;
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			r <= '0;
		else
			r <= n;
	end

	assign o_level = r.s2;
	assign o_rise  = r.s2 & ~r.s3;  // [R10]
endmodule
`default_nettype wire

// File: verilog/nmd_nco_mixer.sv
// module: phase accumulator, sine lookup and complex mixer
`timescale 1ns/100ps
`default_nettype none
module nmd_nco_mixer
(
	// clock and reset
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_arst_n,
	// samples
	input  wire logic signed [nmd_pkg::SMP_W-1:0] i_smp,
	input  wire logic                          i_smp_valid,
	// control
	input  wire logic [nmd_pkg::NCO_W-1:0]     i_freq_pend,
	input  wire logic                          i_restart,
	input  wire logic                          i_invert,
	input  wire logic                          i_bypass,
	output logic [nmd_pkg::NCO_W-1:0]          o_freq_act,
	// mixed stream
	nmd_iq_if.src                              iq
);
	import nmd_pkg::*;

	typedef struct packed {
		logic [NCO_W-1:0]        phase;
		logic [NCO_W-1:0]        freq;
		logic signed [ACC_W-1:0] i;
		logic signed [ACC_W-1:0] q;
		logic                    vld;
	} nmd_nco_st_t;

	nmd_nco_st_t r;
	nmd_nco_st_t n;

	function automatic logic signed [AMP_W-1:0] sin_lu
	(
		input logic [PIDX_W-1:0] p
	);
		logic [15:0] a;
		a = p[4] ? SIN_LUT[~p[3:0]] : SIN_LUT[p[3:0]];
		sin_lu = p[5] ? -$signed({1'b0, a}) : $signed({1'b0, a});
	endfunction

	logic [PIDX_W-1:0]              pidx;
	logic signed [AMP_W-1:0]        cos_v;
	logic signed [AMP_W-1:0]        sin_v;
	logic signed [SMP_W+AMP_W-1:0]  prod_i;
	logic signed [SMP_W+AMP_W-1:0]  prod_q;

	always_comb
	begin
		n      = r;
		pidx   = r.phase[NCO_W-1 -: PIDX_W];
		cos_v  = sin_lu(pidx + PIDX_W'(QTR_OFS));
		sin_v  = sin_lu(pidx);
		// inversion conjugates the sequence  [R1] [R5]
		if (i_invert)
			sin_v = -sin_v;
		prod_i = i_smp * cos_v;  // [R3]
		prod_q = i_smp * sin_v;  // [R3]
		n.vld  = i_smp_valid;
		if (i_bypass)
		begin
			// real path skips the mixer  [R16]
			n.i = ACC_W'(i_smp) <<< SMP_SHIFT;
			n.q = '0;
		end
		else
		begin
			n.i = prod_i[SMP_W+AMP_W-3 -: ACC_W];
			n.q = prod_q[SMP_W+AMP_W-3 -: ACC_W];
		end
		if (i_restart)
		begin
			n.phase = '0;  // [R4] [R12]
			n.freq  = i_freq_pend;  // [R4] [R12]
		end
		else if (i_smp_valid)
			n.phase = r.phase + r.freq;  // [R1] [R2]
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			r       <= '0;
			r.freq  <= FREQ_RST;
		end
		else
			r <= n;
	end

	assign iq.i       = r.i;
	assign iq.q       = r.q;
	assign iq.vld     = r.vld;
	assign o_freq_act = r.freq;
endmodule
`default_nettype wire

// File: verilog/nmd_top.sv
// module: apb registers, alignment control and decimation filter
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module nmd_top
(
	// clock and reset
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_arst_n,

	// apb slave
	input  wire logic                          i_psel,
	input  wire logic                          i_penable,
	input  wire logic                          i_pwrite,
	input  wire logic [nmd_pkg::ADR_W-1:0]     i_paddr,
	input  wire logic [nmd_pkg::DAT_W-1:0]     i_pwdata,
	output logic [nmd_pkg::DAT_W-1:0]          o_prdata,
	output logic                               o_pready,
	output logic                               o_pslverr,

	// adc samples
	input  wire logic signed [nmd_pkg::SMP_W-1:0] i_smp,
	input  wire logic                          i_smp_valid,

	// shared powerdown / alignment pin
	input  wire logic                          i_powerdown_align_pin,
	output logic                               o_powerdown,

	// filtered output
	output logic signed [nmd_pkg::ACC_W-1:0]   o_dout_i,
	output logic signed [nmd_pkg::ACC_W-1:0]   o_dout_q,
	output logic                               o_dout_valid,
	output logic                               o_dout_real
);
	import nmd_pkg::*;

	typedef struct packed {
		// register file
		logic [DAT_W-1:0]        ctrl;
		logic [NCO_W-1:0]        freq;
		logic                    pend;
		logic                    aligned;
		logic                    restart;
		logic                    align;
		// apb answer
		logic [DAT_W-1:0]        prdata;
		logic                    pready;
		logic                    pslverr;
		// decimator
		logic [CNT_W-1:0]        cnt;
		logic signed [SUM_W-1:0] acc_i;
		logic signed [SUM_W-1:0] acc_q;
		// output stage
		logic signed [ACC_W-1:0] dout_i;
		logic signed [ACC_W-1:0] dout_q;
		logic                    dout_vld;
		logic                    dout_real;
		logic                    pdn;
	} nmd_top_st_t;

	nmd_top_st_t r;
	nmd_top_st_t n;

	nmd_iq_if iq ();

	logic             pin_level;
	logic             pin_rise;
	logic [NCO_W-1:0] freq_act;

	// control decode
	logic                 dec_en;
	logic                 real_m;
	logic                 invert;
	logic                 gain_en;
	logic                 align_en;
	logic [RATIO_W-1:0]   ratio_raw;
	logic [RATIO_W-1:0]   ratio;
	logic [CNT_W-1:0]     last;
	logic                 align_evt;
	logic                 restart_evt;
	// apb decode
	logic                 apb_setup;
	logic                 apb_wr;
	logic [DAT_W-1:0]     stat_word;
	logic [DAT_W-1:0]     rd_word;
	logic                 rd_err;
	// filter arithmetic
	logic signed [SUM_W-1:0] sum_i;
	logic signed [SUM_W-1:0] sum_q;
	logic signed [SUM_W-1:0] avg_i;
	logic signed [SUM_W-1:0] avg_q;

	// saturation limits of the 20-bit output word
	localparam logic signed [ACC_W+1:0] SAT_HI =
		(ACC_W+2)'($signed({1'b0, {(ACC_W-1){1'b1}}}));
	localparam logic signed [ACC_W+1:0] SAT_LO =
		(ACC_W+2)'($signed({1'b1, {(ACC_W-1){1'b0}}}));

	// fixed gain with saturation back to 20 bits
	function automatic logic signed [ACC_W-1:0] gain_sat
	(
		input logic signed [ACC_W-1:0] v,
		input logic                    en,
		input logic                    real_mode
	);
		logic signed [ACC_W+1:0] w;
		logic signed [ACC_W+1:0] g;
		w = (ACC_W+2)'(v);
		// real gain is about root two, built from shifts
		if (!en)
			g = w;
		else if (real_mode)
			g = w + (w >>> 2) + (w >>> 3) + (w >>> 5);
		else
			g = w <<< 1;
		if (g > SAT_HI)
			gain_sat = SAT_HI[ACC_W-1:0];
		else if (g < SAT_LO)
			gain_sat = SAT_LO[ACC_W-1:0];
		else
			gain_sat = g[ACC_W-1:0];
	endfunction

	nmd_pin_sync u_pin_sync
	(
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_pin     (i_powerdown_align_pin),
		.o_level   (pin_level),
		.o_rise    (pin_rise)
	);

	nmd_nco_mixer u_nco_mixer
	(
		.i_sys_clk   (i_sys_clk),
		.i_arst_n    (i_arst_n),
		.i_smp       (i_smp),
		.i_smp_valid (i_smp_valid),
		.i_freq_pend (r.freq),
		.i_restart   (restart_evt),
		.i_invert    (invert),
		.i_bypass    (real_m | ~dec_en),
		.o_freq_act  (freq_act),
		.iq          (iq)
	);

	assign dec_en    = r.ctrl[CTRL_DEC_EN];
	assign real_m    = r.ctrl[CTRL_REAL];
	assign invert    = r.ctrl[CTRL_INVERT];
	assign gain_en   = r.ctrl[CTRL_GAIN];
	assign align_en  = r.ctrl[CTRL_ALIGN_EN];
	assign ratio_raw = r.ctrl[CTRL_RATIO_LO +: RATIO_W];

	// pin role chosen by software  [R9]
	assign align_evt   = r.align | (align_en & pin_rise);  // [R13]
	// restart reloads the word, divider phase untouched
	assign restart_evt = r.restart | align_evt;  // [R4] [R12]

	assign apb_setup = i_psel & ~i_penable;
	assign apb_wr    = i_psel & i_penable & r.pready & i_pwrite;

	always_comb
	begin
		stat_word               = '0;
		stat_word[STAT_PDN]     = r.pdn;
		stat_word[STAT_ALIGNED] = r.aligned;
		stat_word[STAT_PEND]    = r.pend;
	end

	// register read mux, also flags unmapped addresses
	always_comb
	begin
		rd_word = '0;
		rd_err  = 1'b0;
		case (i_paddr)
			ADDR_CTRL: rd_word = r.ctrl;
			ADDR_FREQ: rd_word = r.freq;
			ADDR_CMD:  rd_word = '0;
			ADDR_STAT: rd_word = stat_word;
			ADDR_FACT: rd_word = freq_act;
			default:   rd_err  = 1'b1;
		endcase
	end

	// ratio codes above the largest clamp to 32  [R7]
	always_comb
	begin
		ratio = (ratio_raw > RATIO_MAX) ? RATIO_MAX : ratio_raw;
		last  = {CNT_W{1'b1}} >> (RATIO_MAX - ratio);
		sum_i = r.acc_i + {{(SUM_W-ACC_W){iq.i[ACC_W-1]}}, iq.i};
		sum_q = r.acc_q + {{(SUM_W-ACC_W){iq.q[ACC_W-1]}}, iq.q};
		avg_i = sum_i >>> (ratio + RATIO_W'(1));  // [R17]
		avg_q = sum_q >>> (ratio + RATIO_W'(1));  // [R17]
	end

	always_comb
	begin
		n          = r;
		n.restart  = 1'b0;
		n.align    = 1'b0;
		n.dout_vld = 1'b0;
		// no wait states: answer in the first access cycle
		n.pready   = apb_setup;
		n.pdn      = ~align_en & pin_level;  // [R9]

		// read data prepared during the setup phase
		if (apb_setup)
		begin
			n.prdata  = rd_word;
			n.pslverr = rd_err;
		end

		// loading the word clears pending; a new write wins
		if (restart_evt)
			n.pend = 1'b0;

		if (apb_wr)
		begin
			case (i_paddr)
				ADDR_CTRL: n.ctrl = i_pwdata & CTRL_MASK;
				ADDR_FREQ:
				begin
					n.freq = i_pwdata;  // [R4]
					n.pend = 1'b1;
				end
				ADDR_CMD:
				begin
					n.restart = i_pwdata[CMD_RESTART];  // [R4]
					n.align   = i_pwdata[CMD_ALIGN];  // [R13]
				end
				ADDR_STAT:
				begin
					if (i_pwdata[STAT_ALIGNED])
						n.aligned = 1'b0;
				end
				default: n.ctrl = r.ctrl;
			endcase
		end

		if (align_evt)
			n.aligned = 1'b1;

		// decimator: dividers reset only by alignment  [R14]
		if (align_evt)
		begin
			n.cnt   = '0;  // [R11]
			n.acc_i = '0;  // [R11]
			n.acc_q = '0;  // [R11]
		end
		else if (iq.vld)
		begin
			// filter off: mixer bypassed too, each sample scaled by 16 passes straight out
			if (!dec_en)
			begin
				n.dout_i    = iq.i;
				n.dout_q    = iq.q;
				n.dout_vld  = 1'b1;
				n.dout_real = 1'b0;
			end
			else if (r.cnt == last)
			begin
				// I and Q dumped on the same sample  [R11] [R19]
				n.cnt       = '0;
				n.acc_i     = '0;
				n.acc_q     = '0;
				n.dout_i    = gain_sat(avg_i[ACC_W-1:0], gain_en,
					real_m);  // [R18]
				n.dout_q    = real_m ? '0 :
					gain_sat(avg_q[ACC_W-1:0], gain_en, 1'b0);  // [R8]
				n.dout_vld  = 1'b1;  // [R7] [R19]
				n.dout_real = real_m;  // [R8] [R16]
			end
			// still integrating: carry the running sums
			else
			begin
				n.cnt   = r.cnt + CNT_W'(1);
				n.acc_i = sum_i;
				n.acc_q = sum_q;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			r      <= '0;
			r.ctrl <= CTRL_RST;
			r.freq <= FREQ_RST;
		end
		else
			r <= n;
	end

	// every output straight from a register
	assign o_prdata     = r.prdata;
	assign o_pready     = r.pready;
	assign o_pslverr    = r.pslverr;
	assign o_powerdown  = r.pdn;
	assign o_dout_i     = r.dout_i;
	assign o_dout_q     = r.dout_q;
	assign o_dout_valid = r.dout_vld;
	assign o_dout_real  = r.dout_real;
endmodule
`default_nettype wire

// File: sim/nmd_top_assertions.sv
// checker: port relations of the nco mixer decimator top
`timescale 1ns/100ps
`default_nettype none
module nmd_top_chk
	import nmd_pkg::*;
(
	// clock and reset
	input wire logic                    i_sys_clk,
	input wire logic                    i_arst_n,
	// apb
	input wire logic                    i_psel,
	input wire logic                    i_penable,
	input wire logic                    i_pwrite,
	input wire logic [ADR_W-1:0]        i_paddr,
	input wire logic [DAT_W-1:0]        i_pwdata,
	input wire logic [DAT_W-1:0]        o_prdata,
	input wire logic                    o_pready,
	input wire logic                    o_pslverr,
	// stream and pin
	input wire logic signed [SMP_W-1:0] i_smp,
	input wire logic                    i_smp_valid,
	input wire logic                    i_powerdown_align_pin,
	input wire logic                    o_powerdown,
	input wire logic signed [ACC_W-1:0] o_dout_i,
	input wire logic signed [ACC_W-1:0] o_dout_q,
	input wire logic                    o_dout_valid,
	input wire logic                    o_dout_real
);
	logic [DAT_W-1:0] ctrl_reg;

	// shadow of the control word, updated on the completing write
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
		if (!i_arst_n)
			ctrl_reg <= CTRL_RST;
		else if (i_psel && i_penable && o_pready && i_pwrite
			&& i_paddr == ADDR_CTRL)
			ctrl_reg <= i_pwdata;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);

	a_ready_setup: assert property (
		i_psel && !i_penable |=> o_pready) else $error("pready late");
	a_ready_single: assert property (
		o_pready |=> !o_pready) else $error("pready too long");
	a_unmapped_err: assert property (
		i_psel && !i_penable && i_paddr > ADDR_FACT
		|=> o_pslverr && o_prdata == '0) else $error("unmapped answer");
	a_bypass_word: assert property (
		!ctrl_reg[CTRL_DEC_EN] && i_smp_valid |-> ##2 o_dout_valid
		&& o_dout_i == {$past(i_smp, 2), 4'h0} && o_dout_q == '0)
		else $error("bypass word wrong");
	a_decim_strobe: assert property (
		ctrl_reg[CTRL_DEC_EN] && o_dout_valid |=> !o_dout_valid)
		else $error("strobe too long");
	a_real_qzero: assert property (
		o_dout_valid && o_dout_real |-> o_dout_q == '0)
		else $error("real q not zero");
	a_real_flag: assert property (
		o_dout_valid && ctrl_reg[CTRL_DEC_EN]
		|-> o_dout_real == ctrl_reg[CTRL_REAL]) else $error("real flag");
	a_pdn_follows: assert property (
		(i_powerdown_align_pin && !ctrl_reg[CTRL_ALIGN_EN]) [*5]
		|-> o_powerdown) else $error("powerdown missing");
	a_pdn_blocked: assert property (
		ctrl_reg[CTRL_ALIGN_EN] [*2] |-> !o_powerdown)
		else $error("powerdown in align role");
	a_pdn_low: assert property (
		!i_powerdown_align_pin [*5] |-> !o_powerdown)
		else $error("powerdown stuck");
endmodule
bind nmd_top nmd_top_chk u_chk (.*);
`default_nettype wire

// File: sim/nmd_adc_model.sv
// partner: adc sample source sending spaced bursts
`timescale 1ns/100ps
`default_nettype none
module nmd_adc_model
	import nmd_pkg::*;
(
	// clock and reset
	input wire logic                    i_sys_clk,
	input wire logic                    i_arst_n,
	// burst request
	input wire logic                    i_go,
	input wire logic [5:0]              i_num,
	input wire logic signed [SMP_W-1:0] i_val,
	// sample stream
	output logic signed [SMP_W-1:0]     o_smp,
	output logic                        o_smp_valid
);
	logic [5:0] left_reg;
	logic [1:0] gap_reg;
	logic       fire;

	assign fire = (gap_reg == 2'h3) && (left_reg != 6'h0);

	// one sample every fourth cycle; idle data toggles
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			left_reg    <= 6'h0;
			gap_reg     <= 2'h0;
			o_smp_valid <= 1'b0;
			o_smp       <= '0;
		end
		else
		begin
			gap_reg     <= gap_reg + 2'h1;
			o_smp_valid <= fire;
			o_smp       <= fire ? i_val : ~o_smp;
			if (i_go)
				left_reg <= i_num;
			else if (fire)
				left_reg <= left_reg - 6'h1;
		end
	end
endmodule
`default_nettype wire

// File: sim/nmd_top_test.sv
// testbench: register, alignment and decimation scenarios
`timescale 1ns/100ps
`default_nettype none
module nmd_top_test;
	import nmd_pkg::*;
	logic                    i_sys_clk, i_arst_n, i_psel, i_penable, i_pwrite;
	logic [ADR_W-1:0]        i_paddr;
	logic [DAT_W-1:0]        i_pwdata, o_prdata, rd;
	logic                    o_pready, o_pslverr, err, i_smp_valid, go;
	logic signed [SMP_W-1:0] i_smp, val;
	logic                    i_powerdown_align_pin, o_powerdown;
	logic signed [ACC_W-1:0] o_dout_i, o_dout_q, di, dq, qa;
	logic                    o_dout_valid, o_dout_real, dreal;
	logic [5:0]              num;
	int                      fails = 0, n_tests = 0, cyc = 0, cnt;

	nmd_top dut (.*);
	nmd_adc_model u_adc (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
		.i_go(go), .i_num(num), .i_val(val), .o_smp(i_smp),
		.o_smp_valid(i_smp_valid));

	initial
	begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask

	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] d);
		@(posedge i_sys_clk);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= wr;
		i_paddr   <= a;
		i_pwdata  <= d;
		@(posedge i_sys_clk);
		i_penable <= 1'b1;
		do
			@(posedge i_sys_clk);
		while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask

	// send n samples, count them until the first output word
	task automatic burst(input logic [5:0] n, input logic [SMP_W-1:0] v);
		@(posedge i_sys_clk);
		go  <= 1'b1;
		num <= n;
		val <= v;
		cnt = 0;
		@(posedge i_sys_clk);
		go <= 1'b0;
		do
		begin
			@(posedge i_sys_clk);
			#1;
			cnt += int'(i_smp_valid);
		end
		while (o_dout_valid !== 1'b1);
		di = o_dout_i;
		dq = o_dout_q;
		dreal = o_dout_real;
		repeat (8) @(posedge i_sys_clk);
	endtask

	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			print_verdict();
		end
	end

	initial
	begin
		i_arst_n = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = '0;
		i_pwdata = '0;
		i_powerdown_align_pin = 1'b0;
		go = 1'b0;
		num = 6'h0;
		val = '0;
		repeat (3) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		apb(1'b0, ADDR_CTRL, '0);
		chk("ctrl", CTRL_RST, rd);
		apb(1'b0, ADDR_FREQ, '0);
		chk("freq", FREQ_RST, rd);
		// minus half rate: (fs - fs/2) * 2^32 / fs
		apb(1'b1, ADDR_FREQ, 32'h8000_0000);
		apb(1'b0, ADDR_FREQ, '0);
		chk("freq", 32'h8000_0000, rd);
		apb(1'b0, ADDR_FACT, '0);
		chk("fact", FREQ_RST, rd);
		apb(1'b0, ADDR_STAT, '0);
		chk("pend", 32'h1, 32'(rd[STAT_PEND]));
		apb(1'b1, ADDR_CMD, 32'h1);
		apb(1'b0, ADDR_FACT, '0);
		chk("fact", 32'h8000_0000, rd);
		apb(1'b0, 8'h40, '0);
		chk("slverr", 32'h1, 32'(err));
		chk("unmapped rd", 32'h0, rd);
		i_powerdown_align_pin <= 1'b1;
		repeat (5) @(posedge i_sys_clk);
		chk("pdn", 32'h1, 32'(o_powerdown));
		apb(1'b0, ADDR_STAT, '0);
		chk("stat pdn", 32'h1, 32'(rd[STAT_PDN]));
		i_powerdown_align_pin <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h10);
		apb(1'b1, ADDR_FREQ, 32'h1234_5678);
		@(posedge i_sys_clk);
		i_powerdown_align_pin <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		chk("pdn", 32'h0, 32'(o_powerdown));
		apb(1'b0, ADDR_FACT, '0);
		chk("fact", 32'h1234_5678, rd);
		apb(1'b0, ADDR_STAT, '0);
		chk("aligned", 32'h1, 32'(rd[STAT_ALIGNED]));
		i_powerdown_align_pin <= 1'b0;
		apb(1'b1, ADDR_STAT, 32'h2);
		apb(1'b0, ADDR_STAT, '0);
		chk("aligned", 32'h0, 32'(rd[STAT_ALIGNED]));
		apb(1'b1, ADDR_CMD, 32'h2);
		apb(1'b0, ADDR_STAT, '0);
		chk("aligned", 32'h1, 32'(rd[STAT_ALIGNED]));
		for (int k = 0; k < 5; k++)
		begin
			apb(1'b1, ADDR_CTRL, 32'((k << CTRL_RATIO_LO) | 1));
			// realign only while the stream is idle
			apb(1'b1, ADDR_CMD, 32'h2);
			burst(6'(2 << k), 16'h0100);
			chk("ratio", 32'(2 << k), 32'(cnt));
		end
		apb(1'b1, ADDR_CTRL, 32'h3);
		apb(1'b1, ADDR_CMD, 32'h2);
		burst(6'h2, 16'h0100);
		chk("real", 32'h1, 32'(dreal));
		chk("real i", 32'h1000, 32'(di));
		apb(1'b1, ADDR_CTRL, 32'hb);
		apb(1'b1, ADDR_CMD, 32'h2);
		burst(6'h2, 16'h0100);
		chk("gain", 32'h1, 32'(di > 20'sh1000 && di < 20'sh2000));
		apb(1'b1, ADDR_FREQ, '0);
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b1, ADDR_CMD, 32'h2);
		burst(6'h2, 16'h0100);
		qa = dq;
		chk("q", 32'h1, 32'(qa != '0));
		apb(1'b1, ADDR_CTRL, 32'h9);
		apb(1'b1, ADDR_CMD, 32'h2);
		burst(6'h2, 16'h0100);
		chk("gain q", 32'(qa) << 1, 32'(dq));
		apb(1'b1, ADDR_CTRL, 32'h5);
		apb(1'b1, ADDR_CMD, 32'h2);
		burst(6'h2, 16'h0100);
		chk("inv q", 32'(-qa), 32'(dq));
		apb(1'b1, ADDR_CTRL, '0);
		burst(6'h1, 16'h8001);
		chk("bypass", 32'hfff8_0010, 32'(di));
		chk("count", 32'h1, 32'(cnt));
		print_verdict();
	end
endmodule
`default_nettype wire
